// >>> src/mtr_pkg.sv
// package: constants, types and lookups for the metering register access bridge
package mtr_pkg;

    // ------------------------------------------------------------
    // register bus offsets
    // ------------------------------------------------------------
    localparam logic [7:0] MTR_POINTER_ADDR = 8'h91; // pointer, direction flag on top bit
    localparam logic [7:0] MTR_DATA_LOW = 8'h92;
    localparam logic [7:0] MTR_DATA_MIDDLE = 8'h93;
    localparam logic [7:0] MTR_DATA_HIGH = 8'h94;
    localparam logic [7:0] MTR_VRMS_LOW = 8'hd1;
    localparam logic [7:0] MTR_VRMS_MIDDLE = 8'hd2;
    localparam logic [7:0] MTR_VRMS_HIGH = 8'hd3;
    localparam logic [7:0] MTR_IRMS_LOW = 8'hd4;
    localparam logic [7:0] MTR_IRMS_MIDDLE = 8'hd5;
    localparam logic [7:0] MTR_IRMS_HIGH = 8'hd6;
    localparam logic [7:0] MTR_IRQ_EN_LOW = 8'hd9;
    localparam logic [7:0] MTR_IRQ_EN_MIDDLE = 8'hda;
    localparam logic [7:0] MTR_IRQ_EN_HIGH = 8'hdb;
    localparam logic [7:0] MTR_IRQ_ST_LOW = 8'hdc;
    localparam logic [7:0] MTR_IRQ_ST_MIDDLE = 8'hdd;
    localparam logic [7:0] MTR_IRQ_ST_HIGH = 8'hde;
    localparam logic [7:0] MTR_WAV1_LOW = 8'he2;
    localparam logic [7:0] MTR_WAV1_MIDDLE = 8'he3;
    localparam logic [7:0] MTR_WAV1_HIGH = 8'he4;
    localparam logic [7:0] MTR_WAV2_LOW = 8'he5;
    localparam logic [7:0] MTR_WAV2_MIDDLE = 8'he6;
    localparam logic [7:0] MTR_WAV2_HIGH = 8'he7;

    // ------------------------------------------------------------
    // pointer field layout
    // ------------------------------------------------------------
    localparam int MTR_PTR_DIR_BIT = 7; // 1 = write, 0 = read
    localparam int MTR_PTR_ADDR_MSB = 6;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] MTR_BYTE_RESET = 8'h00;
    localparam logic [23:0] MTR_WORD_RESET = 24'h000000;

    // ------------------------------------------------------------
    // timing: metering core clock and transfer bound
    // ------------------------------------------------------------
    localparam int MTR_SYS_CLK_HZ = 10_000_000; // sys_clk rate
    localparam int MTR_BASE_CLK_HZ = 4_096_000; // base clock of the metering core
    localparam int MTR_CORE_DIV = 5; // metering core divider
    localparam int MTR_CORE_CLK_HZ = MTR_BASE_CLK_HZ / MTR_CORE_DIV; // 819.2 kHz
    localparam int MTR_CORE_XFER_CYCLES = 8; // core answers within this many of its cycles
    localparam int MTR_SYNC_SLACK = 4; // sys cycles lost in the three-flop crossing
    // longest wait rounds down to whole sys_clk cycles, plus crossing slack
    localparam int MTR_XFER_TIMEOUT_CYC =
        (MTR_CORE_XFER_CYCLES * MTR_SYS_CLK_HZ) / MTR_CORE_CLK_HZ + MTR_SYNC_SLACK;
    localparam int MTR_TMO_W = 8;

    // ------------------------------------------------------------
    // transfer state machine
    // ------------------------------------------------------------
    typedef enum logic {
        MTR_XF_IDLE,
        MTR_XF_WAIT
    } mtr_xfer_state_t;

    // internal registers only one byte wide
    function automatic logic mtr_is_one_byte(input logic [6:0] addr);
        case (addr)
            7'h0b, 7'h0c, 7'h0d, 7'h0e, 7'h0f, 7'h10, 7'h13, 7'h1b: mtr_is_one_byte = 1'b1;
            default: mtr_is_one_byte = 1'b0;
        endcase
    endfunction

    // accumulators that clear once read (the active energy read-clear among them)
    function automatic logic mtr_is_read_clear(input logic [6:0] addr);
        case (addr)
            7'h02, 7'h05, 7'h08, 7'h18, 7'h1a: mtr_is_read_clear = 1'b1;
            default: mtr_is_read_clear = 1'b0;
        endcase
    endfunction

endpackage

// >>> src/mtr_sfr_bridge.sv
// metering register access bridge: direct result bytes and pointer-driven indirect access
//
// Functional notes
// - pointer top bit write, low seven address
// - pointer write with flag copies data bytes
// - one-byte target takes low data byte only
// - pointer write without flag loads data bytes
// - one-byte read zeroes middle and high bytes
// - metering core clocked separately, asynchronous phase
// - interrupt status bytes captured live on each read
// - high byte read latches whole 24-bit group
// - low or middle read gives previous sample
// - pointer and data bytes at 0x91-0x94
// - rms voltage and current read-only bytes
// - interrupt enable and status byte registers
// - waveform sample bytes read-only at 0xe2-0xe7
// - read-clear accumulators clear after the read
`timescale 1ns/1ps
`default_nettype none

module mtr_sfr_bridge (
    input wire logic sys_clk,
    input wire logic rst,
    // register bus from the cpu core
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    output logic sfr_hit,
    // live values from the metering core domain
    input wire logic [23:0] vrms_live,
    input wire logic [23:0] irms_live,
    input wire logic [23:0] wav1_live,
    input wire logic [23:0] wav2_live,
    input wire logic [23:0] irq_status_live,
    // interrupt controls toward the metering core
    output logic [23:0] irq_enable,
    output logic [23:0] irq_status_wdata,
    output logic irq_status_wr_tgl,
    // indirect transfer handshake toward the metering core
    output logic mc_req_tgl,
    output logic mc_write,
    output logic [6:0] mc_addr,
    output logic [23:0] mc_wdata,
    output logic mc_read_clear,
    input wire logic mc_ack_tgl,
    input wire logic [23:0] mc_rdata,
    // transfer status
    output logic xfer_busy,
    output logic xfer_timeout
);

    // ------------------------------------------------------------
    // state record
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] pointer; // last pointer written
        logic [23:0] data; // data bytes, high:middle:low
        logic [23:0] vrms_sh; // latched rms voltage
        logic [23:0] irms_sh; // latched rms current
        logic [23:0] wav1_sh; // latched waveform one
        logic [23:0] wav2_sh; // latched waveform two
        logic [23:0] irq_en; // interrupt enable bytes
        logic [23:0] irq_st_sh; // status bytes as last captured
        logic [23:0] irq_wdata; // status bytes as last written
        logic irq_wr_tgl; // flips on each status write
        logic [7:0] rdata; // read answer
        logic hit; // last access hit a mapped byte
        mtr_pkg::mtr_xfer_state_t xf; // transfer state
        logic req_tgl; // request toggle toward the core
        logic ack_seen; // last acknowledge toggle taken
        logic write; // direction of the pending transfer
        logic [6:0] addr; // internal register address
        logic [23:0] wdata; // data carried by a write
        logic rd_clear; // read of a clear-on-read accumulator
        logic [mtr_pkg::MTR_TMO_W-1:0] tmo; // wait counter
        logic timeout; // sticky: a transfer got no answer
    } mtr_state_t;

    mtr_state_t st;
    mtr_state_t next_st;

    // ------------------------------------------------------------
    // crossings from the metering core domain
    // ------------------------------------------------------------
    logic [23:0] vrms_s; // synchronised rms voltage
    logic [23:0] irms_s; // synchronised rms current
    logic [23:0] wav1_s; // synchronised waveform one
    logic [23:0] wav2_s; // synchronised waveform two
    logic [23:0] irq_st_s; // synchronised interrupt status
    logic [23:0] mc_rdata_s; // synchronised read data
    logic ack_s; // synchronised acknowledge toggle

    // the metering core runs on its own divided clock, so every input
    // from it is treated as asynchronous and passes three flops
    // asynchronous core crossing
    mtr_sync3 #(.W(24)) u_sync_vrms (.sys_clk(sys_clk), .rst(rst), .async_in(vrms_live), .sync_out(vrms_s));
    mtr_sync3 #(.W(24)) u_sync_irms (.sys_clk(sys_clk), .rst(rst), .async_in(irms_live), .sync_out(irms_s));
    mtr_sync3 #(.W(24)) u_sync_wav1 (.sys_clk(sys_clk), .rst(rst), .async_in(wav1_live), .sync_out(wav1_s));
    mtr_sync3 #(.W(24)) u_sync_wav2 (.sys_clk(sys_clk), .rst(rst), .async_in(wav2_live), .sync_out(wav2_s));
    mtr_sync3 #(.W(24)) u_sync_irq (.sys_clk(sys_clk), .rst(rst), .async_in(irq_status_live),
        .sync_out(irq_st_s));
    // read data is held by the core from before its acknowledge flips,
    // so it settles through the same depth no later than the acknowledge
    mtr_sync3 #(.W(24)) u_sync_rdata (.sys_clk(sys_clk), .rst(rst), .async_in(mc_rdata),
        .sync_out(mc_rdata_s));
    mtr_sync3 #(.W(1)) u_sync_ack (.sys_clk(sys_clk), .rst(rst), .async_in(mc_ack_tgl),
        .sync_out(ack_s));

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;

        // ---- register reads ----
        if (sfr_rd) begin
            next_st.hit = 1'b1;
            case (sfr_addr)
                mtr_pkg::MTR_POINTER_ADDR: next_st.rdata = st.pointer;
                mtr_pkg::MTR_DATA_LOW: next_st.rdata = st.data[7:0];
                mtr_pkg::MTR_DATA_MIDDLE: next_st.rdata = st.data[15:8];
                mtr_pkg::MTR_DATA_HIGH: next_st.rdata = st.data[23:16];
                // low and middle give latched sample
                mtr_pkg::MTR_VRMS_LOW: next_st.rdata = st.vrms_sh[7:0];
                mtr_pkg::MTR_VRMS_MIDDLE: next_st.rdata = st.vrms_sh[15:8];
                mtr_pkg::MTR_VRMS_HIGH: begin
                    next_st.vrms_sh = vrms_s;
                    next_st.rdata = vrms_s[23:16];
                end
                mtr_pkg::MTR_IRMS_LOW: next_st.rdata = st.irms_sh[7:0];
                mtr_pkg::MTR_IRMS_MIDDLE: next_st.rdata = st.irms_sh[15:8];
                mtr_pkg::MTR_IRMS_HIGH: begin
                    next_st.irms_sh = irms_s;
                    next_st.rdata = irms_s[23:16];
                end
                mtr_pkg::MTR_IRQ_EN_LOW: next_st.rdata = st.irq_en[7:0];
                mtr_pkg::MTR_IRQ_EN_MIDDLE: next_st.rdata = st.irq_en[15:8];
                mtr_pkg::MTR_IRQ_EN_HIGH: next_st.rdata = st.irq_en[23:16];
                mtr_pkg::MTR_IRQ_ST_LOW: begin
                    next_st.irq_st_sh[7:0] = irq_st_s[7:0];
                    next_st.rdata = irq_st_s[7:0];
                end
                mtr_pkg::MTR_IRQ_ST_MIDDLE: begin
                    next_st.irq_st_sh[15:8] = irq_st_s[15:8];
                    next_st.rdata = irq_st_s[15:8];
                end
                mtr_pkg::MTR_IRQ_ST_HIGH: begin
                    next_st.irq_st_sh[23:16] = irq_st_s[23:16];
                    next_st.rdata = irq_st_s[23:16];
                end
                mtr_pkg::MTR_WAV1_LOW: next_st.rdata = st.wav1_sh[7:0];
                mtr_pkg::MTR_WAV1_MIDDLE: next_st.rdata = st.wav1_sh[15:8];
                mtr_pkg::MTR_WAV1_HIGH: begin
                    next_st.wav1_sh = wav1_s;
                    next_st.rdata = wav1_s[23:16];
                end
                mtr_pkg::MTR_WAV2_LOW: next_st.rdata = st.wav2_sh[7:0];
                mtr_pkg::MTR_WAV2_MIDDLE: next_st.rdata = st.wav2_sh[15:8];
                mtr_pkg::MTR_WAV2_HIGH: begin
                    next_st.wav2_sh = wav2_s;
                    next_st.rdata = wav2_s[23:16];
                end
                // unmapped bytes answer zero and drop the hit flag
                default: begin
                    next_st.rdata = mtr_pkg::MTR_BYTE_RESET;
                    next_st.hit = 1'b0;
                end
            endcase
        end

        // ---- register writes ----
        // read-only bytes ignore writes; a write never changes rdata
        if (sfr_wr) begin
            next_st.hit = 1'b1;
            case (sfr_addr)
                mtr_pkg::MTR_DATA_LOW: next_st.data[7:0] = sfr_wdata;
                mtr_pkg::MTR_DATA_MIDDLE: next_st.data[15:8] = sfr_wdata;
                mtr_pkg::MTR_DATA_HIGH: next_st.data[23:16] = sfr_wdata;
                // pointer storage; the transfer starts further down
                mtr_pkg::MTR_POINTER_ADDR: next_st.pointer = sfr_wdata;
                mtr_pkg::MTR_IRQ_EN_LOW: next_st.irq_en[7:0] = sfr_wdata;
                mtr_pkg::MTR_IRQ_EN_MIDDLE: next_st.irq_en[15:8] = sfr_wdata;
                mtr_pkg::MTR_IRQ_EN_HIGH: next_st.irq_en[23:16] = sfr_wdata;
                // status writes passed to the core
                mtr_pkg::MTR_IRQ_ST_LOW: begin
                    next_st.irq_wdata[7:0] = sfr_wdata;
                    next_st.irq_wr_tgl = ~st.irq_wr_tgl;
                end
                mtr_pkg::MTR_IRQ_ST_MIDDLE: begin
                    next_st.irq_wdata[15:8] = sfr_wdata;
                    next_st.irq_wr_tgl = ~st.irq_wr_tgl;
                end
                mtr_pkg::MTR_IRQ_ST_HIGH: begin
                    next_st.irq_wdata[23:16] = sfr_wdata;
                    next_st.irq_wr_tgl = ~st.irq_wr_tgl;
                end
                default: begin
                    next_st.hit = (sfr_addr >= mtr_pkg::MTR_VRMS_LOW && sfr_addr <= mtr_pkg::MTR_IRMS_HIGH)
                        || (sfr_addr >= mtr_pkg::MTR_WAV1_LOW && sfr_addr <= mtr_pkg::MTR_WAV2_HIGH);
                end
            endcase
        end

        // ---- indirect transfer engine ----
        case (st.xf)
            mtr_pkg::MTR_XF_IDLE: begin
                // a pointer write launches one transfer; while a transfer is
                // pending a new pointer is stored but launches nothing, which is
                // why software must wait between accesses
                // launch only when idle
                if (sfr_wr && sfr_addr == mtr_pkg::MTR_POINTER_ADDR) begin
                    next_st.write = sfr_wdata[mtr_pkg::MTR_PTR_DIR_BIT];
                    next_st.addr = sfr_wdata[mtr_pkg::MTR_PTR_ADDR_MSB:0];
                    // data bytes carried by a write
                    next_st.wdata = st.data;
                    // one-byte target sees low byte only
                    if (mtr_pkg::mtr_is_one_byte(sfr_wdata[mtr_pkg::MTR_PTR_ADDR_MSB:0])) begin
                        next_st.wdata = {16'h0000, st.data[7:0]};
                    end
                    next_st.rd_clear = ~sfr_wdata[mtr_pkg::MTR_PTR_DIR_BIT]
                        && mtr_pkg::mtr_is_read_clear(sfr_wdata[mtr_pkg::MTR_PTR_ADDR_MSB:0]);
                    next_st.req_tgl = ~st.req_tgl;
                    next_st.tmo = '0;
                    next_st.xf = mtr_pkg::MTR_XF_WAIT;
                end
            end
            mtr_pkg::MTR_XF_WAIT: begin
                if (ack_s != st.ack_seen) begin
                    next_st.ack_seen = ack_s;
                    next_st.rd_clear = 1'b0;
                    next_st.xf = mtr_pkg::MTR_XF_IDLE;
                    if (!st.write) begin
                        next_st.data = mc_rdata_s;
                        if (mtr_pkg::mtr_is_one_byte(st.addr)) begin
                            next_st.data = {16'h0000, mc_rdata_s[7:0]};
                        end
                    end
                end else if (st.tmo == mtr_pkg::MTR_TMO_W'(mtr_pkg::MTR_XFER_TIMEOUT_CYC - 1)) begin
                    // bounded wait, then give up
                    // a late acknowledge is absorbed as the next one seen, so
                    // ack_seen is flipped ahead of the synced toggle to stay in step
                    next_st.ack_seen = ~st.ack_seen;
                    next_st.timeout = 1'b1;
                    next_st.rd_clear = 1'b0;
                    next_st.xf = mtr_pkg::MTR_XF_IDLE;
                end else begin
                    next_st.tmo = st.tmo + 1'b1;
                end
            end
            default: begin
                next_st.xf = mtr_pkg::MTR_XF_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st <= '0;
            st.xf <= mtr_pkg::MTR_XF_IDLE;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // outputs, each straight from the state register
    // ------------------------------------------------------------
    assign sfr_rdata = st.rdata;
    assign sfr_hit = st.hit;
    assign irq_enable = st.irq_en;
    assign irq_status_wdata = st.irq_wdata;
    assign irq_status_wr_tgl = st.irq_wr_tgl;
    assign mc_req_tgl = st.req_tgl;
    assign mc_write = st.write;
    assign mc_addr = st.addr;
    assign mc_wdata = st.wdata;
    assign mc_read_clear = st.rd_clear;
    assign xfer_busy = (st.xf == mtr_pkg::MTR_XF_WAIT);
    assign xfer_timeout = st.timeout;

endmodule // mtr_sfr_bridge

`default_nettype wire

// >>> src/mtr_sync3.sv
// three-flop input synchroniser that passes a value once stages two and three agree
`timescale 1ns/1ps
`default_nettype none

module mtr_sync3 #(
    parameter int W = 1
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [W-1:0] s1; // first stage, read by s2 only
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q; // accepted value
    } mtr_sync_state_t;

    mtr_sync_state_t st;
    mtr_sync_state_t next_st;

    // shift and accept only stable values; while any bit still toggles the whole word is held back
    always_comb begin
        next_st = st;
        next_st.s1 = async_in;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        if (st.s2 == st.s3) begin
            next_st.q = st.s3;
        end
    end

    // register the state
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign sync_out = st.q;

endmodule // mtr_sync3

`default_nettype wire

// >>> verification/mtr_core_model.sv
// partner model: metering core side of the indirect transfer handshake
`timescale 1ns/1ps
`default_nettype none
module mtr_core_model (
    input wire logic [7:0] core_delay,
    input wire logic mc_req_tgl,
    input wire logic mc_write,
    input wire logic [6:0] mc_addr,
    input wire logic [23:0] mc_wdata,
    input wire logic mc_read_clear,
    output logic mc_ack_tgl,
    output logic [23:0] mc_rdata
);
    logic core_clk = 1'b0; // phase unrelated to the bus clock
    logic seen = 1'b0; // last request toggle served
    logic [23:0] mem [128]; // internal register page, upper bytes filled on purpose
    always #610.352 core_clk = ~core_clk;
    initial begin
        mc_ack_tgl = 1'b0;
        mc_rdata = 24'h000000;
        for (int i = 0; i < 128; i++) mem[i] = {1'b1, i[6:0], 1'b0, i[6:0], 1'b1, i[6:0]};
    end
    // serve one request, data settles a cycle before the ack
    always @(posedge core_clk) begin
        if (mc_req_tgl != seen) begin
            seen = mc_req_tgl;
            repeat (core_delay) @(posedge core_clk);
            if (mc_write) mem[mc_addr] = mc_wdata;
            else begin
                mc_rdata = mem[mc_addr];
                if (mc_read_clear) mem[mc_addr] = 24'h000000;
            end
            @(posedge core_clk);
            mc_ack_tgl = ~mc_ack_tgl;
        end
    end
endmodule // mtr_core_model
`default_nettype wire

// >>> verification/mtr_sfr_bridge_monitor.sv
// checker: port-level properties of the metering register bridge
`timescale 1ns/1ps
`default_nettype none
module mtr_bridge_chk (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic sfr_hit,
    input wire logic [23:0] irq_enable,
    input wire logic mc_req_tgl,
    input wire logic mc_write,
    input wire logic [6:0] mc_addr,
    input wire logic [23:0] mc_wdata,
    input wire logic mc_read_clear,
    input wire logic xfer_busy
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic ptr; // any pointer write
    logic go; // pointer write that must launch
    logic one_b; // written target is one byte wide
    logic mapped; // address names a bridge byte
    assign ptr = sfr_wr && sfr_addr == 8'h91;
    assign go = ptr && !xfer_busy;
    assign one_b = sfr_wdata[6:0] inside {[7'h0b:7'h10], 7'h13, 7'h1b};
    assign mapped = sfr_addr inside {[8'h91:8'h94], [8'hd1:8'hd6], [8'hd9:8'hde], [8'he2:8'he7]};
    a_launch_flips: assert property (go |=> $changed(mc_req_tgl) && xfer_busy)
        else $error("pointer write launched nothing");
    a_pointer_fields: assert property (go |=> {mc_write, mc_addr} == $past(sfr_wdata))
        else $error("direction or address lost");
    a_busy_refused: assert property (ptr && xfer_busy |=> $stable(mc_req_tgl))
        else $error("launch while busy");
    a_busy_bounded: assert property ($rose(xfer_busy) |-> ##[1:120] !xfer_busy)
        else $error("transfer never ended");
    a_one_byte_write: assert property (go && sfr_wdata[7] && one_b |=> mc_wdata[23:8] == 16'h0000)
        else $error("upper bytes sent to one-byte target");
    a_unmapped_read: assert property (sfr_rd && !mapped |=> sfr_rdata == 8'h00 && !sfr_hit)
        else $error("unmapped read answered");
    a_enable_store: assert property (sfr_wr && sfr_addr == 8'hd9 |=> irq_enable[7:0] == $past(sfr_wdata))
        else $error("enable byte not stored");
    a_clear_on_read: assert property (mc_read_clear |-> xfer_busy && !mc_write)
        else $error("clear flag outside a read");
    c_launch: cover property (go);
    c_refused: cover property (ptr && xfer_busy);
    c_read_clear: cover property ($rose(mc_read_clear));
endmodule // mtr_bridge_chk
bind mtr_sfr_bridge mtr_bridge_chk u_mtr_bridge_chk (.sys_clk, .rst, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata,
    .sfr_rdata, .sfr_hit, .irq_enable, .mc_req_tgl, .mc_write, .mc_addr, .mc_wdata, .mc_read_clear, .xfer_busy);
`default_nettype wire

// >>> verification/tb_top.sv
// testbench: register bus stimulus and checks for the metering bridge
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic sys_clk = 1'b0, rst = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0;
    logic sfr_hit, busy, tmo, req, ack, wr_dir, rclr, irq_swt;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
    logic [7:0] dly = 8'h01; // core answer delay in core cycles
    logic [7:0] grp [4] = '{8'hd1, 8'hd4, 8'he2, 8'he5}; // low byte of each result group
    logic [7:0] rw [6] = '{8'hd9, 8'hda, 8'hdb, 8'h92, 8'h93, 8'h94}; // read-write bytes
    logic [23:0] live [5] = '{default: 24'h000000}; // live words from the core
    logic [23:0] d, e, f, irq_en, irq_sw, mc_wdata, mc_rdata;
    logic [31:0] seed = 32'habd16395;
    logic [6:0] a, r;
    int error_cnt = 0, checks = 0, cyc = 0;
    always #50 sys_clk = ~sys_clk;
    mtr_sfr_bridge u_mtr_sfr_bridge (.sys_clk, .rst, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .sfr_hit,
        .vrms_live(live[0]), .irms_live(live[1]), .wav1_live(live[2]), .wav2_live(live[3]),
        .irq_status_live(live[4]), .irq_enable(irq_en), .irq_status_wdata(irq_sw), .irq_status_wr_tgl(irq_swt),
        .mc_req_tgl(req), .mc_write(wr_dir), .mc_addr(a), .mc_wdata, .mc_read_clear(rclr), .mc_ack_tgl(ack),
        .mc_rdata, .xfer_busy(busy), .xfer_timeout(tmo));
    mtr_core_model u_mtr_core_model (.core_delay(dly), .mc_req_tgl(req), .mc_write(wr_dir), .mc_addr(a),
        .mc_wdata, .mc_read_clear(rclr), .mc_ack_tgl(ack), .mc_rdata);
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // one-byte targets keep only the low byte
    function automatic logic [23:0] fit(input logic [6:0] t, input logic [23:0] v);
        return (t inside {[7'h0b:7'h10], 7'h13, 7'h1b}) ? {16'h0000, v[7:0]} : v;
    endfunction
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        checks++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            error_cnt++;
        end
    endtask
    // one strobe per access, driven and dropped on falling edges
    task automatic acc(input logic w, input logic [7:0] ad, input logic [7:0] wd);
        @(negedge sys_clk);
        sfr_addr = ad;
        sfr_wdata = wd;
        sfr_wr = w;
        sfr_rd = !w;
        @(negedge sys_clk);
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
    endtask
    task automatic rd(input logic [7:0] ad, input logic [7:0] exp);
        acc(1'b0, ad, 8'h00);
        chk({16'h0000, sfr_rdata}, {16'h0000, exp});
    endtask
    task automatic rd3(input logic [23:0] x);
        for (int k = 0; k < 3; k++) rd(8'h92 + 8'(k), x[8*k +: 8]);
    endtask
    // software waits for the transfer to finish before touching the bytes
    task automatic wt();
        @(negedge sys_clk);
        for (int i = 0; i < 150 && busy === 1'b1; i++) @(negedge sys_clk);
        chk({23'h000000, busy}, 24'h000000);
    endtask
    task automatic xfer(input logic [7:0] p);
        acc(1'b1, 8'h91, p);
        wt();
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // watchdog: the run needs far fewer cycles than this
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            end_of_test();
        end
    end
    initial begin
        repeat (16) @(posedge sys_clk);
        @(negedge sys_clk);
        rst = 1'b0;
        for (int g = 0; g < 4; g++) begin
            d = seed[23:0];
            live[g] = d;
            repeat (6) @(negedge sys_clk);
            rd(grp[g] + 8'h02, d[23:16]);
            seed = lfsr(seed);
            live[g] = seed[23:0];
            repeat (6) @(negedge sys_clk);
            acc(1'b1, grp[g] + 8'h01, 8'hff);
            chk({23'h000000, sfr_hit}, 24'h000001);
            rd(grp[g] + 8'h01, d[15:8]);
            rd(grp[g], d[7:0]);
            rd(grp[g] + 8'h02, seed[23:16]);
        end
        for (int k = 0; k < 3; k++) begin
            seed = lfsr(seed);
            live[4] = seed[23:0];
            repeat (6) @(negedge sys_clk);
            rd(8'hdc + 8'(k), seed[8*k +: 8]);
            // status writes go to the core, each one flips the toggle
            f[8*k +: 8] = seed[31:24];
            acc(1'b1, 8'hdc + 8'(k), seed[31:24]);
        end
        chk(irq_sw, f);
        chk({23'h000000, irq_swt}, 24'h000001);
        for (int k = 0; k < 6; k++) begin
            seed = lfsr(seed);
            if (k < 3) e[8*k +: 8] = seed[7:0];
            acc(1'b1, rw[k], seed[7:0]);
            rd(rw[k], seed[7:0]);
        end
        chk(irq_en, e);
        rd(8'h95, 8'h00);
        chk({23'h000000, sfr_hit}, 24'h000000);
        acc(1'b1, 8'h91, 8'h02);
        acc(1'b1, 8'h91, 8'h0c);
        wt();
        rd(8'h91, 8'h0c);
        rd3({1'b1, 7'h02, 1'b0, 7'h02, 1'b1, 7'h02});
        xfer(8'h02);
        rd3(24'h000000);
        xfer(8'h0c);
        rd3({16'h0000, 1'b1, 7'h0c});
        for (int n = 0; n < 6; n++) begin
            seed = lfsr(seed);
            dly = {6'h00, seed[31:30]} + 8'h01;
            // first pass forces a one-byte target so the low-byte-only path runs
            r = (n == 0) ? 7'h13 : seed[30:24];
            d = seed[23:0];
            for (int k = 0; k < 3; k++) acc(1'b1, 8'h92 + 8'(k), d[8*k +: 8]);
            xfer({1'b1, r});
            chk(mc_wdata, fit(r, d));
            xfer({1'b0, r});
            rd(8'h91, {1'b0, r});
            rd3(fit(r, d));
        end
        dly = 8'hff;
        xfer(8'h01);
        chk({23'h000000, tmo}, 24'h000001);
        end_of_test();
    end
endmodule // tb_top
`default_nettype wire
